/* File: hw/lgp_link_gpio_port.sv */
// four-pin gpio port of the serializer with forward and back channel linking
`default_nettype none
// How it works
// [R01] four pins 0..3 controlled through registers 0x0d, 0x0e, 0x53
// [R02] reading 0x53 returns live level of every pin, input or output
// [R03] after reset all four pins are inputs, input enables set
// [R04] bits 3:0 of 0x0e are per-pin input enables
// [R05] bits 7:4 of 0x0e are per-pin output enables
// [R06] software never sets input and output enable of one pin together
// [R07] up to four input levels are forwarded in forward-channel frames
// [R08] one linked pin is sampled and sent in every frame
// [R09] two linked pins are sampled once every two frames
// [R10] three or four linked pins are sampled once every five frames
// [R11] forwarded levels arrive about 225 ns later; jitter grows with period
// [R12] forwarded inputs should toggle at most a quarter of sampling rate
// [R13] an output pin may drive remote back-channel data, chosen via 0x0d
// [R14] back-channel data sampled at 1670, 334 or 83.5 kHz by clock mode
// [R15] pins 0 and 1 can route their input to the voltage sensing function
// [R16] a sensed pin gives a 3-bit code feeding limit checks and alarms
// [R17] pin with both enables clear does not drive, forwards zero
// [R18] output pin not selecting remote data drives the local value
module lgp_link_gpio_port
    import lgp_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // register access from the device's i2c target
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    output var  logic [7:0]       reg_rdata,
    // pads
    input  wire logic [3:0]       pin_in,
    output var  logic [3:0]       pin_out,
    output var  logic [3:0]       pin_oe,
    // forward channel
    input  wire logic             fwd_frame,
    input  wire logic [2:0]       forward_linked_pin_count,
    output var  lgp_fwd_type      fwd_sample,
    // back channel
    input  wire lgp_clk_mode_type clk_mode,
    input  wire logic [3:0]       bc_data,
    // voltage sensing
    input  wire logic [1:0]       sense_sel,
    input  wire logic [2:0]       sense_adc_code,
    output var  logic             sense_level,
    output var  lgp_sense_type    sense_status
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]    out_src_reg;
    logic [7:0]    dir_ctrl_reg;
    logic [7:0]    rdata_reg;
    logic [3:0]    pin_out_reg;
    logic [3:0]    pin_oe_reg;
    logic [2:0]    frame_cnt_reg;
    lgp_fwd_type   fwd_reg;
    logic [10:0]   bc_cnt_reg;
    logic [3:0]    bc_data_reg;
    logic          sense_level_reg;
    lgp_sense_type sense_reg;
    logic [3:0]    in_en;
    logic [3:0]    out_en;
    logic [3:0]    remote_sel;
    logic [3:0]    local_val;
    logic [3:0]    link_mask;
    logic [2:0]    fwd_period;
    logic [10:0]   bc_period;
    logic          fwd_take;
    logic [2:0]    frames_since_take_reg;
    logic [2:0]    count_at_take_reg;

    // frame spacing for a given number of linked pins
    function automatic logic [2:0] fwd_period_of(input logic [2:0] cnt);
        if (cnt <= 3'h1) begin
            fwd_period_of = FWD_PERIOD_ONE;
        end else if (cnt == 3'h2) begin
            fwd_period_of = FWD_PERIOD_TWO;
        end else begin
            fwd_period_of = FWD_PERIOD_MANY;
        end
    endfunction

    // linked pins are taken lowest first, so a count of n up to 4 links pins 0..n-1; any higher count links all four
    function automatic logic [3:0] link_mask_of(input logic [2:0] cnt);
        case (cnt)
            3'h0:    link_mask_of = 4'h0;
            3'h1:    link_mask_of = 4'h1;
            3'h2:    link_mask_of = 4'h3;
            3'h3:    link_mask_of = 4'h7;
            default: link_mask_of = 4'hf;
        endcase
    endfunction

    // field views of the control registers
    assign in_en      = dir_ctrl_reg[DIR_IN_LSB +: 4];     // see [R04]
    assign out_en     = dir_ctrl_reg[DIR_OUT_LSB +: 4];    // see [R05]
    assign remote_sel = out_src_reg[SRC_REMOTE_LSB +: 4];
    assign local_val  = out_src_reg[SRC_LOCAL_LSB +: 4];
    assign link_mask  = link_mask_of(forward_linked_pin_count);
    assign fwd_period = fwd_period_of(forward_linked_pin_count);
    // a single linked pin never waits on a counter left over from a longer period
    assign fwd_take   = fwd_frame && (link_mask != 4'h0)
                        && ((frame_cnt_reg == 3'h0) || (fwd_period == FWD_PERIOD_ONE));

    // ************************************************************
    // register file
    // ************************************************************
    // writes land in one cycle; the status register has no write effect
    always_ff @(posedge clk) begin
        if (rst) begin
            out_src_reg  <= RST_OUT_SRC;
            dir_ctrl_reg <= RST_DIR_CTRL;                  // see [R03]
        end else if (reg_wr) begin
            if (reg_addr == ADDR_OUT_SRC) begin
                out_src_reg <= reg_wdata;                  // see [R13]
            end
            if (reg_addr == ADDR_DIR_CTRL) begin
                dir_ctrl_reg <= reg_wdata;                 // see [R01]
            end
        end
    end

    // read data is registered; unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            case (reg_addr)
                ADDR_OUT_SRC:  rdata_reg <= out_src_reg;
                ADDR_DIR_CTRL: rdata_reg <= dir_ctrl_reg;
                ADDR_PIN_STS:  rdata_reg <= {4'h0, pin_in}; // see [R02]
                default:       rdata_reg <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // output drivers
    // ************************************************************
    // the pad level feeds status either way, so an output pin reads back its drive
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_oe_reg  <= 4'h0;
            pin_out_reg <= 4'h0;
        end else begin
            pin_oe_reg  <= out_en;                          // see [R17]
            pin_out_reg <= out_en & ((remote_sel & bc_data_reg)
                                   | (~remote_sel & local_val)); // see [R13] see [R18]
        end
    end

    // ************************************************************
    // forward channel sampling
    // ************************************************************
    // frame counter runs only on frame strobes; samples land on count zero
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_cnt_reg <= 3'h0;
        end else if (fwd_frame) begin
            if (frame_cnt_reg >= fwd_period - 3'h1) begin
                frame_cnt_reg <= 3'h0;                     // see [R09] see [R10]
            end else begin
                frame_cnt_reg <= frame_cnt_reg + 3'h1;
            end
        end
    end

    // non-input pins forward zero so a floating pad never reaches the far end;
    // the sample leaves one cycle after its frame, the rest of the latency is framing
    always_ff @(posedge clk) begin
        if (rst) begin
            fwd_reg <= '0;
        end else begin
            fwd_reg.valid <= fwd_take;                     // see [R07] see [R08] see [R11]
            if (fwd_take) begin
                fwd_reg.level <= pin_in & in_en & link_mask; // see [R17]
            end
        end
    end

    // ************************************************************
    // back channel sampling
    // ************************************************************
    always_comb begin
        case (clk_mode)
            LGP_MODE_SYNC:  bc_period = BC_SYNC_CYC;
            LGP_MODE_ASYNC: bc_period = BC_ASYNC_CYC;
            default:        bc_period = BC_PAR_CYC;
        endcase
    end

    // remote values are only as fresh as the mode's sampling tick
    always_ff @(posedge clk) begin
        if (rst) begin
            bc_cnt_reg  <= 11'h000;
            bc_data_reg <= 4'h0;
        end else if (bc_cnt_reg >= bc_period - 11'h001) begin
            bc_cnt_reg  <= 11'h000;
            bc_data_reg <= bc_data;                        // see [R14]
        end else begin
            bc_cnt_reg <= bc_cnt_reg + 11'h001;
        end
    end

    // ************************************************************
    // voltage sensing
    // ************************************************************
    // pin 0 wins if both are selected; the converter itself lives outside
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_level_reg <= 1'b0;
            sense_reg       <= '0;
        end else begin
            sense_level_reg <= sense_sel[0] ? pin_in[0] :
                               (sense_sel[1] ? pin_in[1] : 1'b0); // see [R15]
            if (sense_sel != 2'h0) begin
                sense_reg.code  <= sense_adc_code;          // see [R16]
                sense_reg.below <= sense_adc_code < SENSE_LOW_LIMIT;
                sense_reg.above <= sense_adc_code > SENSE_HIGH_LIMIT;
            end
        end
    end

    // outputs straight from flops
    assign reg_rdata    = rdata_reg;
    assign pin_out      = pin_out_reg;
    assign pin_oe       = pin_oe_reg;
    assign fwd_sample   = fwd_reg;
    assign sense_level  = sense_level_reg;
    assign sense_status = sense_reg;

    // ************************************************************
    // checks
    // ************************************************************
    // check-only history: frames since the last take and the count that take used,
    // so the spacing checks skip the first take after a count change
    always_ff @(posedge clk) begin
        if (rst) begin
            frames_since_take_reg <= 3'h0;
            count_at_take_reg     <= 3'h0;
        end else if (fwd_frame) begin
            if (fwd_take) begin
                frames_since_take_reg <= 3'h1;
                count_at_take_reg     <= forward_linked_pin_count;
            end else if (frames_since_take_reg != 3'h7) begin
                frames_since_take_reg <= frames_since_take_reg + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RESET_INPUTS: assert property ($fell(rst) |-> dir_ctrl_reg == RST_DIR_CTRL) // see [R03]
        else $error("direction register not all inputs after reset");
    AST_STATUS_LIVE: assert property (reg_addr == ADDR_PIN_STS // see [R02]
        |=> reg_rdata == {4'h0, $past(pin_in)})
        else $error("status read does not show pad level");
    AST_OE_FOLLOWS: assert property (1'b1 |=> pin_oe == $past(dir_ctrl_reg[7:4])) // see [R05]
        else $error("output enable differs from control bits");
    AST_IDLE_PIN_ZERO: assert property (fwd_take && !in_en[0] // see [R17]
        |=> !fwd_sample.level[0])
        else $error("non-input pin forwarded as one");
    AST_ONE_EVERY_FRAME: assert property (fwd_frame // see [R08]
        && forward_linked_pin_count == 3'h1 |=> fwd_sample.valid)
        else $error("single linked pin missed a frame");
    AST_TWO_SPACING: assert property (fwd_take && forward_linked_pin_count == 3'h2 // see [R09]
        && count_at_take_reg == 3'h2 |-> frames_since_take_reg == FWD_PERIOD_TWO)
        else $error("two linked pins not sampled every second frame");
    AST_MANY_SPACING: assert property (fwd_take && forward_linked_pin_count >= 3'h3 // see [R10]
        && count_at_take_reg == forward_linked_pin_count
        |-> frames_since_take_reg == FWD_PERIOD_MANY)
        else $error("three or more linked pins not sampled every fifth frame");
    AST_LOCAL_DRIVE: assert property (out_en[1] && !remote_sel[1] // see [R18]
        |=> pin_out[1] == $past(local_val[1]))
        else $error("output pin not driving local value");
    AST_NO_FWD_WHEN_ZERO: assert property (forward_linked_pin_count == 3'h0 // see [R07]
        |=> !fwd_sample.valid)
        else $error("sample sent with no linked pins");
endmodule
`default_nettype wire

/* File: hw/lgp_pkg.sv */
// constants and carrier types for the link gpio port
`default_nettype none
package lgp_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_OUT_SRC   = 8'h0d; // pin_output_data_source
    localparam logic [7:0] ADDR_DIR_CTRL  = 8'h0e; // pin_direction_control
    localparam logic [7:0] ADDR_PIN_STS   = 8'h53; // pin_level_status
    localparam logic [7:0] RST_OUT_SRC    = 8'h00;
    localparam logic [7:0] RST_DIR_CTRL   = 8'h0f; // all four pins are inputs
    localparam int         DIR_IN_LSB     = 0;     // input enables in bits 3:0
    localparam int         DIR_OUT_LSB    = 4;     // output enables in bits 7:4
    localparam int         SRC_LOCAL_LSB  = 0;     // local output values in bits 3:0
    localparam int         SRC_REMOTE_LSB = 4;     // remote data selects in bits 7:4

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          BC_SYNC_HZX10   = 16_700_000; // 1670 kHz, tenths of Hz
    localparam int          BC_ASYNC_HZX10  = 3_340_000;  // 334 kHz
    localparam int          BC_PAR_HZX10    = 835_000;    // 83.5 kHz
    localparam logic [10:0] BC_SYNC_CYC     = 11'((CLK_HZ / BC_SYNC_HZX10) * 10 / 1 == 0 ? 1 :
                                                  (longint'(CLK_HZ) * 10) / BC_SYNC_HZX10);
    localparam logic [10:0] BC_ASYNC_CYC    = 11'((longint'(CLK_HZ) * 10) / BC_ASYNC_HZX10);
    localparam logic [10:0] BC_PAR_CYC      = 11'((longint'(CLK_HZ) * 10) / BC_PAR_HZX10);
    localparam logic [2:0]  FWD_PERIOD_ONE  = 3'h1; // one linked pin: every frame
    localparam logic [2:0]  FWD_PERIOD_TWO  = 3'h2; // two linked pins: every 2nd frame
    localparam logic [2:0]  FWD_PERIOD_MANY = 3'h5; // three or four: every 5th frame
    localparam logic [2:0]  SENSE_LOW_LIMIT  = 3'h1;
    localparam logic [2:0]  SENSE_HIGH_LIMIT = 3'h6;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        LGP_MODE_SYNC,
        LGP_MODE_ASYNC,
        LGP_MODE_PARALLEL
    } lgp_clk_mode_type;

    typedef struct packed {
        logic       valid; // one-cycle pulse, one cycle after the frame strobe that took the sample
        logic [3:0] level; // sampled levels, pin n in bit n
    } lgp_fwd_type;

    typedef struct packed {
        logic [2:0] code;  // latched converter code
        logic       below; // code under low limit
        logic       above; // code over high limit
    } lgp_sense_type;
endpackage
`default_nettype wire

/* File: testbench/lgp_link_gpio_port_bench.sv */
// self-checking bench for the link gpio port
`default_nettype none
module lgp_link_gpio_port_bench
    import lgp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, reg_wr, fwd_frame, sense_level, clear;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] ext_pad, pin_in, pin_out, pin_oe, bc_data, bc_value, ine, oute, loc, sel;
    logic [2:0] fwd_count, sense_adc_code, frame_gap;
    logic [1:0] sense_sel;
    lgp_fwd_type fwd_sample;
    lgp_sense_type sense_status;
    lgp_clk_mode_type clk_mode;
    logic [31:0] seed, rnd;
    logic [3:0] last_level;
    int valid_seen, bad_count, compares, cycles, k;

    // pad level seen by the input buffer: our driver wins over the outside world
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pad);

    lgp_link_gpio_port i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .fwd_frame(fwd_frame), .forward_linked_pin_count(fwd_count),
        .fwd_sample(fwd_sample), .clk_mode(clk_mode), .bc_data(bc_data),
        .sense_sel(sense_sel), .sense_adc_code(sense_adc_code),
        .sense_level(sense_level), .sense_status(sense_status));
    lgp_remote_model i_far (.clk(clk), .rst(rst), .frame_gap(frame_gap), .bc_value(bc_value),
        .clear(clear), .fwd_frame(fwd_frame), .bc_data(bc_data), .fwd_sample(fwd_sample),
        .valid_seen(valid_seen), .last_level(last_level));

    // ****************************************
    // clock, watchdog and helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // read data is registered, so it is looked at one edge after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask
    task automatic wait_frames(input int n);
        for (k = 0; k < n; k++) begin
            do @(posedge clk); while (fwd_frame !== 1'b1);
        end
    endtask
    // number of samples expected in ten frames for a linked pin count
    function automatic int fwd_expected(input logic [2:0] n);
        return (n == 3'h0) ? 0 : (n == 3'h1) ? 10 : (n == 3'h2) ? 5 : 2;
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 32'h35fd;
        {reg_wr, reg_addr, reg_wdata, ext_pad, bc_value, sense_sel, sense_adc_code} = '0;
        {clear, fwd_count, cycles, bad_count, compares} = '0;
        frame_gap = 3'h3;
        clk_mode = LGP_MODE_SYNC;
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        ext_pad = 4'ha;
        rd(ADDR_DIR_CTRL, RST_DIR_CTRL);
        rd(ADDR_OUT_SRC, RST_OUT_SRC);
        chk({4'h0, pin_oe}, 8'h00);
        rd(8'h40, 8'h00);
        wr(ADDR_PIN_STS, 8'h55);
        rd(ADDR_PIN_STS, 8'h0a);
        $display("test reset done");
        // direction and local drive, first two rounds are corner cases
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            if (i < 2) rnd[7:0] = (i == 0) ? 8'h00 : 8'hf0;
            ine = rnd[3:0];
            oute = rnd[7:4] & ~ine;
            loc = rnd[11:8];
            ext_pad = rnd[15:12];
            sense_sel = rnd[17:16];
            sense_adc_code = rnd[20:18];
            wr(ADDR_DIR_CTRL, {oute, ine});
            wr(ADDR_OUT_SRC, {4'h0, loc});
            rd(ADDR_DIR_CTRL, {oute, ine});
            chk({4'h0, pin_oe}, {4'h0, oute});
            chk({4'h0, pin_out}, {4'h0, oute & loc});
            rd(ADDR_PIN_STS, {4'h0, pin_in});
            chk({4'h0, pin_in}, {4'h0, (oute & loc) | (~oute & ext_pad)});
            chk({7'h0, sense_level}, {7'h0, sense_sel[0] ? pin_in[0] :
                                        sense_sel[1] & pin_in[1]});
            if (sense_sel != 2'h0) begin
                chk({3'h0, sense_status}, {3'h0, sense_adc_code,
                    sense_adc_code < SENSE_LOW_LIMIT, sense_adc_code > SENSE_HIGH_LIMIT});
            end
        end
        $display("test direction done");
        // forward sampling cadence for every linked count, link speed random
        for (int n = 0; n < 6; n++) begin
            rnd = $random(seed);
            ine = rnd[3:0];
            ext_pad = rnd[7:4]; // held across all frames of the round
            frame_gap = rnd[10:8] | 3'h1;
            wr(ADDR_DIR_CTRL, {4'h0, ine});
            fwd_count = n[2:0];
            wait_frames(6);
            @(negedge clk);
            clear = 1'b1;
            @(negedge clk);
            clear = 1'b0;
            wait_frames(10);
            repeat (2) @(negedge clk);
            chk(8'(valid_seen), 8'(fwd_expected(n[2:0])));
            if (n > 0) chk({4'h0, last_level},
                {4'h0, ext_pad & ine & 4'((5'h1 << (n > 4 ? 4 : n)) - 5'h1)});
        end
        $display("test forward done");
        // back-channel data per clocking mode, waiting one sampling period
        wr(ADDR_DIR_CTRL, 8'hf0);
        for (int m = 0; m < 3; m++) begin
            rnd = $random(seed);
            sel = rnd[3:0];
            loc = rnd[7:4];
            wr(ADDR_OUT_SRC, {sel, loc});
            clk_mode = lgp_clk_mode_type'(m);
            bc_value = rnd[11:8];
            repeat ((m == 0) ? 62 : (m == 1) ? 302 : 1200) @(negedge clk);
            chk({4'h0, pin_out}, {4'h0, (sel & bc_value) | (~sel & loc)});
        end
        $display("test back channel done");
        close_out();
    end
endmodule
`default_nettype wire

/* File: testbench/lgp_remote_model.sv */
// remote deserializer model: frame source, back-channel data, sample collector
`default_nettype none
module lgp_remote_model
    import lgp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // control from the bench
    input  wire logic [2:0]  frame_gap,
    input  wire logic [3:0]  bc_value,
    input  wire logic        clear,
    // link side of the serializer
    output var  logic        fwd_frame,
    output var  logic [3:0]  bc_data,
    input  wire lgp_fwd_type fwd_sample,
    // what the far side has seen
    output var  int          valid_seen,
    output var  logic [3:0]  last_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] gap_cnt;

    // frames leave off the sampling edge; a wide gap plays a slow link
    always @(negedge clk) begin
        bc_data <= bc_value;
        if (rst || gap_cnt >= frame_gap) begin
            gap_cnt   <= 3'h0;
            fwd_frame <= !rst;
        end else begin
            gap_cnt   <= gap_cnt + 3'h1;
            fwd_frame <= 1'b0;
        end
    end

    // count forwarded samples and keep the last levels received
    always @(posedge clk) begin
        if (clear) begin
            valid_seen <= 0;
        end else if (fwd_sample.valid) begin
            valid_seen <= valid_seen + 1;
            last_level <= fwd_sample.level;
        end
    end
endmodule
`default_nettype wire
